// ---- logic/pqa_pkg.sv ----
// Purpose: Shared constants and types for preamble qualification and auto transmit
// Assumes: One 100 MHz clock; registers as 32-bit AXI4-Lite words at byte 4*index
// Notes: Register index constants are the printed offsets
// Behaviour
// - Invalid-preamble flag asserts on the clock after a preamble error is seen.
// - Invalid-preamble detector raises an interrupt when no valid preamble is found.
// - Flag held low for 16 bit periods after receive is enabled.
// - Preamble-detected and invalid-preamble indications readable at 04h.
// - Entering transmit with txon and no new packet resends the last packet.
// - Resend by txon only for packets that fit wholly inside the TX FIFO; an autotx start resends any size.
// - With autotx set, transmit starts by itself when TX FIFO is almost full.
// - Auto transmit returns to idle by itself once the packet is sent.
// - Channel filter programmable 620 kHz to 2.6 kHz through registers 1C to 25.
// - 1Ch holds bypass, exponent, filter select; 20h-25h hold ratio, offset, gain.
package pqa_pkg;
  localparam int unsigned SETTLE_BITS  = 16;
  localparam int unsigned TXFIFO_BYTES = 64;
  localparam int unsigned NUM_EV       = 4;
  localparam int unsigned MODEM_BYTES  = 10;
  localparam int unsigned CNT_W        = 5;

  localparam logic [7:0] IDX_DEV_STATE  = 8'h02;
  localparam logic [7:0] IDX_IRQ_ST1    = 8'h03;
  localparam logic [7:0] IDX_IRQ_ST2    = 8'h04;
  localparam logic [7:0] IDX_IRQ_EN     = 8'h05;
  localparam logic [7:0] IDX_IRQ_CLR    = 8'h06;
  localparam logic [7:0] IDX_OP_CTRL1   = 8'h07;
  localparam logic [7:0] IDX_MODEM_LO   = 8'h1c;
  localparam logic [7:0] IDX_MODEM_HI   = 8'h25;
  localparam logic [7:0] IDX_PREA_DET   = 8'h35;
  localparam logic [7:0] IDX_FUNC_CTRL2 = 8'h80;

  localparam logic [7:0]        RST_FUNC_CTRL2 = 8'h00;
  localparam logic [7:0]        RST_PREA_DET   = 8'h20;
  localparam logic [7:0]        RST_OP_CTRL1   = 8'h00;
  localparam logic [7:0]        RST_MODEM      = 8'h00;
  localparam logic [NUM_EV-1:0] RST_IRQ_EN     = 4'h0;

  localparam int unsigned OP_RXON_BIT = 2;
  localparam int unsigned OP_TXON_BIT = 3;
  localparam int unsigned EV_PKT_SENT = 0;
  localparam int unsigned EV_TX_START = 1;
  localparam int unsigned EV_PREA_OK  = 2;
  localparam int unsigned EV_PREA_BAD = 3;

  localparam int unsigned MB_FILT = 0;
  localparam int unsigned MB_OSR  = 4;
  localparam int unsigned MB_MID  = 5;
  localparam int unsigned MB_NC1  = 6;
  localparam int unsigned MB_NC0  = 7;
  localparam int unsigned MB_CR1  = 8;
  localparam int unsigned MB_CR0  = 9;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b11,
    TX_BACK = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic        decim3_bypass;
    logic [2:0]  ndec_exp;
    logic [3:0]  filset;
    logic [10:0] rxosr;
    logic [19:0] ncoff;
    logic [10:0] crgain;
  } modem_cfg_t;

  typedef struct packed {
    logic [2:0] antdiv;
    logic       rxmpk;
    logic       autotx;
    logic       enldm;
    logic       ffclrrx;
    logic       ffclrtx;
  } func_ctrl_t;
endpackage

// ---- logic/settle_blank.sv ----
// Purpose: Counts bit periods after receive enable to blank the invalid flag
// Assumes: bit_tick is one pulse per bit period on core_clk
// Notes: Count restarts whenever receive drops
`timescale 1ns/100ps
module settle_blank
  import pqa_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic rx_on,
  input  wire logic bit_tick,
  output logic      settled
);
  logic [CNT_W-1:0] cnt_r;
  wire              full = (cnt_r == CNT_W'(SETTLE_BITS));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (!rx_on) begin
      cnt_r <= '0;
    end else if (bit_tick && !full) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  assign settled = full;
endmodule

// ---- logic/event_irq.sv ----
// Purpose: Sticky event status, enable mask and one level interrupt
// Assumes: clr is a one-cycle write pulse
// Notes: A new event beats a clear of the same bit
`timescale 1ns/100ps
module event_irq #(
  parameter int unsigned N = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] ev,
  input  wire logic [N-1:0] en,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] status,
  output logic              irq
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          status[i] <= 1'b0;
        end else begin
          status[i] <= ev[i] | (status[i] & ~clr[i]);
        end
      end
    end
  endgenerate

  assign irq = |(status & en);
endmodule

// ---- logic/preamble_qualify_autotx.sv ----
// Purpose: Invalid-preamble qualifier, auto and repeat transmit, modem config registers
// Assumes: Modem and FIFO strobes are synchronous to core_clk
// Notes: AXI4-Lite slave, one write and one read outstanding
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module preamble_qualify_autotx
  import pqa_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = TXFIFO_BYTES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        bit_tick,
  input  wire logic        preamble_err,
  input  wire logic        preamble_detect,
  input  wire logic        tx_fifo_afull,
  input  wire logic        tx_fifo_wr,
  input  wire logic [7:0]  tx_pkt_len,
  input  wire logic        tx_pkt_done,
  output logic             invalid_preamble_flag,
  output logic             rx_on,
  output logic             tx_start,
  output logic             tx_rewind,
  output logic             tx_on_air,
  output modem_cfg_t       modem_cfg,
  output logic      [4:0]  preamble_thresh,
  output func_ctrl_t       func_ctrl,
  output logic             irq
);
  logic [7:0]        op_ctrl1_r;
  logic [7:0]        prea_det_r;
  logic [7:0]        func_ctrl2_r;
  logic [NUM_EV-1:0] irq_en_r;
  logic [7:0]        modem_r [MODEM_BYTES];
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rd_word;
  tx_state_t         state_r;
  tx_state_t         state_nxt;
  logic              fresh_r;
  logic              fit_r;
  logic              replay_r;
  logic              auto_r;
  logic              flag_r;
  logic              flag_nxt;
  logic              det_d_r;
  logic              settled;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] events;
  logic              refuse;

  function automatic logic reg_hit(input logic [11:0] a);
    logic [7:0] x;
    x = a[9:2];
    reg_hit = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
              ((x >= IDX_DEV_STATE && x <= IDX_OP_CTRL1) ||
               (x >= IDX_MODEM_LO && x <= IDX_MODEM_HI) ||
               x == IDX_PREA_DET || x == IDX_FUNC_CTRL2);
  endfunction

  // Write channel: both halves must be present, so no address is ever held alone
  wire       wr_go   = awvalid & wvalid & ~bvalid_r;
  wire [7:0] widx    = awaddr[9:2];
  wire       w_hit   = reg_hit(awaddr);
  wire       wr_en   = wr_go & w_hit & wstrb[0];
  wire [7:0] wbyte   = wdata[7:0];
  wire       wr_op1  = wr_en & (widx == IDX_OP_CTRL1);
  wire       wr_en_r = wr_en & (widx == IDX_IRQ_EN);
  wire       wr_clr  = wr_en & (widx == IDX_IRQ_CLR);
  wire       wr_pre  = wr_en & (widx == IDX_PREA_DET);
  wire       wr_fc2  = wr_en & (widx == IDX_FUNC_CTRL2);
  wire       wr_mod  = wr_en & (widx >= IDX_MODEM_LO) & (widx <= IDX_MODEM_HI);
  wire [7:0] moff    = widx - IDX_MODEM_LO;
  wire       rd_go   = arvalid & ~rvalid_r;
  wire [7:0] ridx    = araddr[9:2];
  wire       r_hit   = reg_hit(araddr);

  assign awready = wr_go;
  assign wready  = wr_go;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = rd_go;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= r_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= r_hit ? rd_word : '0;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Status words carry the sticky events and, in 04h, the live indications
  always_comb begin
    rd_word = '0;
    if (ridx >= IDX_MODEM_LO && ridx <= IDX_MODEM_HI) begin
      rd_word[7:0] = modem_r[4'(ridx - IDX_MODEM_LO)];
    end else begin
      unique case (ridx)
        IDX_DEV_STATE:  rd_word[7:0] = {5'h00, auto_r, state_r};
        IDX_IRQ_ST1:    rd_word[1:0] = status[EV_TX_START:EV_PKT_SENT];
        IDX_IRQ_ST2:    rd_word[7:0] = {flag_r, det_d_r, 4'h0,
                                        status[EV_PREA_BAD:EV_PREA_OK]};
        IDX_IRQ_EN:     rd_word[NUM_EV-1:0] = irq_en_r;
        IDX_OP_CTRL1:   rd_word[7:0] = op_ctrl1_r;
        IDX_PREA_DET:   rd_word[7:0] = {prea_det_r[7:3], 3'h0};
        IDX_FUNC_CTRL2: rd_word[7:0] = func_ctrl2_r;
        default:        rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prea_det_r   <= RST_PREA_DET;
      func_ctrl2_r <= RST_FUNC_CTRL2;
      irq_en_r     <= RST_IRQ_EN;
    end else begin
      if (wr_pre) prea_det_r <= wbyte;
      if (wr_fc2) func_ctrl2_r <= wbyte;
      if (wr_en_r) irq_en_r <= wbyte[NUM_EV-1:0];
    end
  end

  // Software write wins over the self-clear of txon at the end of a send
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ctrl1_r <= RST_OP_CTRL1;
    end else if (wr_op1) begin
      op_ctrl1_r <= wbyte;
    end else if (state_r == TX_BACK || refuse) begin
      op_ctrl1_r[OP_TXON_BIT] <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < MODEM_BYTES; g++) begin : g_modem
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          modem_r[g] <= RST_MODEM;
        end else if (wr_mod && moff == 8'(g)) begin
          modem_r[g] <= wbyte;
        end
      end
    end
  endgenerate

  assign modem_cfg.decim3_bypass = modem_r[MB_FILT][7];
  assign modem_cfg.ndec_exp      = modem_r[MB_FILT][6:4];
  assign modem_cfg.filset        = modem_r[MB_FILT][3:0];
  assign modem_cfg.rxosr         = {modem_r[MB_MID][7:5], modem_r[MB_OSR]};
  assign modem_cfg.ncoff         = {modem_r[MB_MID][3:0], modem_r[MB_NC1],
                                    modem_r[MB_NC0]};
  assign modem_cfg.crgain        = {modem_r[MB_CR1][2:0], modem_r[MB_CR0]};
  assign preamble_thresh         = prea_det_r[7:3];
  assign func_ctrl               = func_ctrl_t'(func_ctrl2_r);

  // Preamble qualification
  assign rx_on = op_ctrl1_r[OP_RXON_BIT];

  settle_blank u_settle (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rx_on    (rx_on),
    .bit_tick (bit_tick),
    .settled  (settled)
  );

  always_comb begin
    flag_nxt = flag_r;
    if (!rx_on || !settled || preamble_detect) begin
      flag_nxt = 1'b0;
    end else if (preamble_err) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r  <= 1'b0;
      det_d_r <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      det_d_r <= preamble_detect;
    end
  end

  assign invalid_preamble_flag = flag_r;

  // Transmit sequencing
  wire txon     = op_ctrl1_r[OP_TXON_BIT];
  wire auto_go  = func_ctrl.autotx & tx_fifo_afull;
  wire pkt_fits = ({24'h0, tx_pkt_len} <= FIFO_DEPTH);
  wire manual   = txon & (fresh_r | fit_r);
  assign refuse = (state_r == TX_IDLE) & txon & ~fresh_r & ~fit_r & ~auto_go;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TX_IDLE: if (auto_go || manual) state_nxt = TX_LOAD;
      TX_LOAD: state_nxt = TX_SEND;
      TX_SEND: if (tx_pkt_done) state_nxt = TX_BACK;
      TX_BACK: state_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= TX_IDLE;
      replay_r <= 1'b0;
      auto_r   <= 1'b0;
      fit_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == TX_IDLE && state_nxt == TX_LOAD) begin
        replay_r <= ~fresh_r;
        auto_r   <= auto_go;
      end
      if (state_r == TX_LOAD && fresh_r) begin
        fit_r <= pkt_fits;
      end
    end
  end

  // A byte written while the load is taken still counts as new data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fresh_r <= 1'b0;
    end else begin
      fresh_r <= tx_fifo_wr | (fresh_r & (state_r != TX_LOAD));
    end
  end

  assign tx_start  = (state_r == TX_LOAD);
  assign tx_rewind = (state_r == TX_LOAD) & replay_r;
  assign tx_on_air = (state_r == TX_SEND);

  assign events[EV_PKT_SENT] = (state_r == TX_BACK);
  assign events[EV_TX_START] = (state_r == TX_LOAD);
  assign events[EV_PREA_OK]  = preamble_detect & ~det_d_r;
  assign events[EV_PREA_BAD] = flag_nxt & ~flag_r;

  event_irq #(.N(NUM_EV)) u_irq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ev       (events),
    .en       (irq_en_r),
    .clr      (wr_clr ? wbyte[NUM_EV-1:0] : {NUM_EV{1'b0}}),
    .status   (status),
    .irq      (irq)
  );

  // Checks
  sequence s_stale_txon;
    state_r == TX_IDLE && txon && !fresh_r && fit_r && !auto_go;
  endsequence

  sequence s_finish;
    state_r == TX_SEND && tx_pkt_done;
  endsequence

  a_blank_holds_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    !settled |=> !invalid_preamble_flag) else $error("flag rose inside settle window");
  a_flag_on_error: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_on && settled && preamble_err && !preamble_detect |=> invalid_preamble_flag)
    else $error("preamble error did not raise flag");
  a_irq_on_invalid: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(invalid_preamble_flag) |-> status[EV_PREA_BAD])
    else $error("invalid preamble not latched");
  a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_go && ridx == IDX_IRQ_ST2 && r_hit |=> rdata[1:0] == $past(status[3:2]))
    else $error("status 04h read wrong");
  a_resend_last: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_stale_txon |=> tx_rewind ##1 tx_on_air) else $error("no resend of last packet");
  a_resend_fits: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == TX_IDLE && txon && !fresh_r && !fit_r && !auto_go |=> !tx_start)
    else $error("resend of oversized packet");
  a_autotx_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == TX_IDLE && func_ctrl.autotx && tx_fifo_afull |=> tx_start ##1 tx_on_air)
    else $error("auto transmit did not start");
  a_auto_return: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_finish |=> state_r == TX_BACK ##1 state_r == TX_IDLE)
    else $error("no return to idle");
  a_filter_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mod && widx == IDX_MODEM_LO |=> modem_cfg.filset == $past(wbyte[3:0]))
    else $error("filter select not stored");
endmodule

// ---- verif/radio_side_model.sv ----
// Purpose: Far side of the block: bit clock, preamble arrival, packet air time
// Assumes: One bit period is TICK_DIV core clocks
// Notes: Air time is chosen per packet by the bench; preamble only after settling
`timescale 1ns/100ps
module radio_side_model #(
  parameter int unsigned TICK_DIV = 4,
  parameter int unsigned DET_BITS = 28
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       rx_on,
  input  wire logic       tx_on_air,
  input  wire logic [3:0] air_cycles,
  output logic            bit_tick,
  output logic            preamble_detect,
  output logic            tx_pkt_done
);
  logic [7:0] div_r;
  logic [7:0] bits_r;
  logic [7:0] air_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r           <= 8'h00;
      bits_r          <= 8'h00;
      air_r           <= 8'h00;
      bit_tick        <= 1'b0;
      preamble_detect <= 1'b0;
      tx_pkt_done     <= 1'b0;
    end else begin
      div_r    <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      bit_tick <= (div_r == 8'(TICK_DIV - 1));
      // Preamble = 1 byte settling + 20-bit threshold, so blanking ends well before
      bits_r <= !rx_on ? 8'h00 : bits_r + {7'h00, bit_tick && bits_r != 8'(DET_BITS)};
      preamble_detect <= rx_on && bits_r == 8'(DET_BITS);
      air_r       <= tx_on_air ? air_r + 8'h01 : 8'h00;
      tx_pkt_done <= tx_on_air && air_r == {4'h0, air_cycles};
    end
  end
endmodule

// ---- verif/test_preamble_qualify_autotx.sv ----
// Purpose: Self-checking bench for preamble qualification and auto transmit
// Assumes: AXI4-Lite master in this file; radio side from the partner model
// Notes: Fixed seed; a watchdog ends a hang
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_preamble_qualify_autotx;
  import pqa_pkg::*;
  logic        core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, bit_tick, preamble_err, preamble_detect;
  logic        tx_fifo_afull, tx_fifo_wr, tx_pkt_done, invalid_preamble_flag, rx_on;
  logic        tx_start, tx_rewind, tx_on_air, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, air_cycles;
  logic [1:0]  bresp, rresp;
  logic [1:0]  wresp;
  logic [7:0]  tx_pkt_len;
  logic [4:0]  preamble_thresh;
  modem_cfg_t  modem_cfg;
  func_ctrl_t  func_ctrl;
  int          fails, compares, starts, rews;
  logic [7:0]  mb [MODEM_BYTES];

  preamble_qualify_autotx uut (.core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bit_tick(bit_tick), .preamble_err(preamble_err),
    .preamble_detect(preamble_detect), .tx_fifo_afull(tx_fifo_afull),
    .tx_fifo_wr(tx_fifo_wr), .tx_pkt_len(tx_pkt_len), .tx_pkt_done(tx_pkt_done),
    .invalid_preamble_flag(invalid_preamble_flag), .rx_on(rx_on), .tx_start(tx_start),
    .tx_rewind(tx_rewind), .tx_on_air(tx_on_air), .modem_cfg(modem_cfg),
    .preamble_thresh(preamble_thresh), .func_ctrl(func_ctrl), .irq(irq));
  radio_side_model radio (.core_clk(core_clk), .rst_n(rst_n), .rx_on(rx_on),
    .tx_on_air(tx_on_air), .air_cycles(air_cycles), .bit_tick(bit_tick),
    .preamble_detect(preamble_detect), .tx_pkt_done(tx_pkt_done));

  always #5 core_clk = ~core_clk;
  // Start pulses last one cycle, so sampling mid-cycle counts each once
  always @(negedge core_clk) begin
    if (tx_start === 1'b1) begin
      starts++;
      rews += int'(tx_rewind === 1'b1);
    end
  end

  function automatic modem_cfg_t exp_modem(input logic [7:0] m [MODEM_BYTES]);
    exp_modem = {m[MB_FILT], m[MB_MID][7:5], m[MB_OSR], m[MB_MID][3:0], m[MB_NC1],
                 m[MB_NC0], m[MB_CR1][2:0], m[MB_CR0]};
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int   n;
    logic hit;
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 100) begin
      @(negedge core_clk);
      hit = awready & wready;
      @(posedge core_clk);
      n++;
    end
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    hit = 1'b0;
    while (!hit && n < 200) begin
      @(negedge core_clk);
      hit = bvalid;
      wresp = bresp;
      @(posedge core_clk);
      n++;
    end
    bready <= 1'b0;
    if (!hit) fails++;
    @(posedge core_clk);
  endtask

  task automatic axr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic hit;
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 100) begin
      @(negedge core_clk);
      hit = arready;
      @(posedge core_clk);
      n++;
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit && n < 200) begin
      @(negedge core_clk);
      hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      n++;
    end
    rready <= 1'b0;
    if (!hit) fails++;
    @(posedge core_clk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axr(idx, d, r);
    `CHK(nm, e, d)
  endtask

  task automatic pulse_err(output logic f);
    preamble_err <= 1'b1;
    @(posedge core_clk);
    preamble_err <= 1'b0;
    @(negedge core_clk);
    f = invalid_preamble_flag;
    @(posedge core_clk);
  endtask

  // One transfer, started by txon or by the almost-full level
  task automatic pkt(input logic [7:0] len, input bit fresh, input bit auto,
                     input int e_st, input int e_rw);
    int          s0, r0, n;
    bit          seen;
    logic [31:0] d;
    logic [1:0]  r;
    s0 = starts;
    r0 = rews;
    air_cycles <= 4'($urandom_range(1, 8));
    if (fresh) begin
      tx_pkt_len <= len;
      tx_fifo_wr <= 1'b1;
      @(posedge core_clk);
      tx_fifo_wr <= 1'b0;
    end
    if (auto) tx_fifo_afull <= 1'b1;
    else wr(IDX_OP_CTRL1, 8'h08);
    n = 0;
    seen = 1'b0;
    // Look at negedges only, where the state outputs have settled
    while (n < 40) begin
      @(negedge core_clk);
      seen = seen | (starts != s0) | (tx_start === 1'b1);
      if (seen && tx_start === 1'b0 && tx_on_air === 1'b0) break;
      @(posedge core_clk);
      if (seen) tx_fifo_afull <= 1'b0;
      n++;
    end
    @(posedge core_clk);
    `CHK("starts", e_st, starts - s0)
    `CHK("rewinds", e_rw, rews - r0)
    axr(IDX_DEV_STATE, d, r);
    `CHK("tx state", TX_IDLE, d[1:0])
    rd_chk(IDX_OP_CTRL1, 32'h0, "txon");
  endtask

  task tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end

  initial begin
    logic        f;
    logic [31:0] d;
    logic [1:0]  r;
    {core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {preamble_err, tx_fifo_afull, tx_fifo_wr, tx_pkt_len, air_cycles} = '0;
    {awaddr, araddr, wdata, fails, compares, starts, rews} = '0;
    wstrb = 4'hf;
    void'($urandom(51143));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(IDX_FUNC_CTRL2, {24'h0, RST_FUNC_CTRL2}, "func ctrl2");
    rd_chk(IDX_PREA_DET, {24'h0, RST_PREA_DET}, "prea det");
    axr(8'h3f, d, r);
    `CHK("unmapped", RESP_SLVERR, r)
    wr(8'h3f, 8'h55);
    `CHK("unmapped wr", RESP_SLVERR, wresp)
    wr(IDX_PREA_DET, 8'h10);
    `CHK("thresh 8", 5'd2, preamble_thresh)
    `CHK("bresp", RESP_OKAY, wresp)
    wr(IDX_PREA_DET, 8'h28);
    `CHK("thresh 20", 5'd5, preamble_thresh)
    wstrb <= 4'h0;
    wr(IDX_PREA_DET, 8'hf8);
    `CHK("no strobe", 5'd5, preamble_thresh)
    wstrb <= 4'hf;
    wr(IDX_OP_CTRL1, 8'h04);
    `CHK("rx on", 1'b1, rx_on)
    repeat (6) @(posedge core_clk);
    pulse_err(f);
    `CHK("blanked flag", 1'b0, f)
    repeat (70) @(posedge core_clk);
    pulse_err(f);
    `CHK("flag", 1'b1, f)
    rd_chk(IDX_IRQ_ST2, 32'h82, "status2 bad");
    `CHK("irq masked", 1'b0, irq)
    wr(IDX_IRQ_EN, 8'h08);
    `CHK("irq", 1'b1, irq)
    wr(IDX_IRQ_CLR, 8'h08);
    `CHK("irq clr", 1'b0, irq)
    repeat (60) @(posedge core_clk);
    rd_chk(IDX_IRQ_ST2, 32'h41, "status2 ok");
    wr(IDX_OP_CTRL1, 8'h00);
    // Diversity on: invalid interrupt stays masked, it may fire falsely
    wr(IDX_IRQ_EN, 8'h00);
    wr(IDX_FUNC_CTRL2, 8'h80);
    `CHK("antdiv", 3'h4, func_ctrl.antdiv)
    pkt(8'd20, 1, 0, 1, 0);
    pkt(8'd20, 0, 0, 1, 1);
    pkt(8'(TXFIFO_BYTES), 1, 0, 1, 0);
    pkt(8'(TXFIFO_BYTES), 0, 0, 1, 1);
    pkt(8'($urandom_range(1, 64)), 1, 0, 1, 0);
    pkt(8'd100, 1, 0, 1, 0);
    pkt(8'd100, 0, 0, 0, 0);
    wr(IDX_FUNC_CTRL2, 8'h08);
    pkt(8'd30, 1, 1, 1, 0);
    rd_chk(IDX_IRQ_ST1, 32'h03, "status1");
    for (int p = 0; p < 2; p++) begin
      foreach (mb[k]) mb[k] = 8'($urandom());
      mb[MB_FILT] = p ? 8'h8e : 8'h51;
      foreach (mb[k]) wr(IDX_MODEM_LO + 8'(k), mb[k]);
      `CHK("modem cfg", exp_modem(mb), modem_cfg)
      rd_chk(IDX_MODEM_LO + 8'h01, {24'h0, mb[1]}, "modem 1d");
    end
    tally_and_finish;
  end
endmodule
